// [verilog/spi_nv_device.sv]
// Device end of the serial nonvolatile memory link: 512-byte array,
// write protection and sequential access, all clocked by the link clock.
// Assumes the master keeps one opcode per select and moves hold only while
// the link clock is low; chip select high restarts the frame logic.
`include "spi_nv_cfg.svh"
`timescale 1ns/100ps

// Functional notes
// - Writes need latch set by prior command
// - Write-protect pin low blocks every write
// - Status: bits 3,2 protect, 1 latch, rest zero
// - Protect bits persist, change only by status write
// - Latch set by command, cleared by write end/command; here the write-end clear lands at the next frame's first clock
// - Protect bits select none, quarter, half, all
// - Writes need latch and pin high; protected stay
// - Opcode bit 3 plus next byte form address
// - Address advances per byte, wraps to zero
// - Each byte stored after eighth clock, unlimited
// - Bytes move most significant bit first
// - Chip select rising ends memory write
// - After read header, input ignored, one bit/clock
// - Chip select rising ends read, releases output
// - Hold low freezes transfer, resumes in place
// - Master moves hold only while clock low
// - Opcode values for the six commands
// - Latch cleared at power-up
// - Sample on rising edge, drive on falling
// - One opcode per chip-select assertion
module spi_nv_device
  import spi_nv_pkg::*;
#(
  parameter int ADDR_W = `NV_ADDR_W
) (
  // Serial link, device side
  spi_nv_if.device         link,
  // Power-on reset, active low
  input  wire logic        rst_b,
  // Status byte as last seen on the link clock
  output      logic [7:0]  statusView
);

  // ========================================================================
  // Elaboration check
  // The opcode carries a single extra address bit, so only 9 bits fit.
  if (ADDR_W != `NV_ADDR_W) begin : g_bad_width
    $error("spi_nv_device: ADDR_W must be 9");
  end

  // ========================================================================
  // Decoding helpers

  // True when the address lies inside the range picked by the protect bits
  function automatic logic isProtected(input logic [1:0]        bp,
                                       input logic [ADDR_W-1:0] a);
    case (bp)
      2'b00:   isProtected = 1'b0;
      2'b01:   isProtected = (a >= `PROT_QTR_BASE);
      2'b10:   isProtected = (a >= `PROT_HALF_BASE);
      default: isProtected = 1'b1;
    endcase
  endfunction : isProtected

  // Status byte layout; the fixed zero bits have no storage behind them
  function automatic logic [7:0] packStatus(input logic [1:0] bp,
                                            input logic       write_enable_latch);
    logic [7:0] s;
    s = `STAT_RESET;
    s[`STAT_BPHI_POS] = bp[1];
    s[`STAT_BPLO_POS] = bp[0];
    s[`STAT_WEL_POS]  = write_enable_latch;
    packStatus = s;
  endfunction : packStatus

  // ========================================================================
  // Storage and state
  logic [7:0]        memArray [0:(1<<ADDR_W)-1];
  dev_state_t        state_q;
  logic [2:0]        bitCnt_q;
  logic [7:0]        shift_q;
  logic [7:0]        txByte_q;
  logic [ADDR_W-1:0] addr_q;
  logic              addrMsb_q;
  logic              isWrite_q;
  logic              wel_q;
  logic              welPend_q;
  logic [1:0]        bp_q;
  logic              drvEnN_q;
  logic              misoBit_q;

  // ========================================================================
  // Edge qualifiers
  // Hold freezes every register except statusView; toggles during a pause do nothing else.
  logic              active;
  logic              byteDone;
  logic [7:0]        byteIn;
  logic [ADDR_W-1:0] addrIn;
  logic [ADDR_W-1:0] addrNext;
  logic              writeOk;

  assign active   = ~link.csN & link.holdN;
  assign byteDone = (bitCnt_q == 3'h7);
  assign byteIn   = {shift_q[6:0], link.mosi};
  assign addrIn   = {addrMsb_q, byteIn};
  assign addrNext = addr_q + 9'h001;
  assign writeOk  = wel_q & link.wpN;

  // ========================================================================
  // Frame sequencer
  // Chip select high is the frame's own end, so it clears the sequencer
  // without needing any further clock edge.
  always_ff @(posedge link.sck or posedge link.csN) begin
    if (link.csN) begin
      state_q   <= ST_OPCODE;
      bitCnt_q  <= 3'h0;
      shift_q   <= 8'h00;
      addrMsb_q <= 1'b0;
      isWrite_q <= 1'b0;
    end else if (link.holdN) begin
      bitCnt_q <= bitCnt_q + 3'h1;
      shift_q  <= byteIn;
      if (byteDone) begin
        case (state_q)
          ST_OPCODE: begin
            addrMsb_q <= byteIn[`OPC_MSB_POS];
            if (byteIn[7:4] == 4'h0 && byteIn[2:0] == `OPC_MEM_RD_LO) begin
              state_q   <= ST_ADDR;
              isWrite_q <= 1'b0;
            end else if (byteIn[7:4] == 4'h0 && byteIn[2:0] == `OPC_MEM_WR_LO) begin
              state_q   <= ST_ADDR;
              isWrite_q <= 1'b1;
            end else if (byteIn == `OPC_STAT_RD) begin
              state_q <= ST_SREAD;
            end else if (byteIn == `OPC_STAT_WR) begin
              state_q <= ST_SWRITE;
            end else begin
              state_q <= ST_IGNORE;
            end
          end
          ST_ADDR:   state_q <= isWrite_q ? ST_WDATA : ST_RDATA;
          ST_SREAD:  state_q <= ST_IGNORE;
          ST_SWRITE: state_q <= ST_IGNORE;
          ST_WDATA:  state_q <= ST_WDATA;
          ST_RDATA:  state_q <= ST_RDATA;
          ST_IGNORE: state_q <= ST_IGNORE;
          default:   state_q <= ST_IGNORE;
        endcase
      end
    end
  end

  // ========================================================================
  // Address counter
  // Advances on every data byte, protected or not, so a stream skips over
  // a protected block without losing its place.
  always_ff @(posedge link.sck or posedge link.csN) begin
    if (link.csN) begin
      addr_q <= '0;
    end else if (link.holdN && byteDone) begin
      if (state_q == ST_ADDR) begin
        addr_q <= addrIn;
      end else if (state_q == ST_WDATA || state_q == ST_RDATA) begin
        addr_q <= addrNext;
      end
    end
  end

  // ========================================================================
  // Array write
  // No page buffer: the byte lands in the same edge that completes it.
  always_ff @(posedge link.sck) begin
    if (active && byteDone && state_q == ST_WDATA && writeOk
        && !isProtected(bp_q, addr_q)) begin
      memArray[addr_q] <= byteIn;
    end
  end

  // ========================================================================
  // Read byte fetch
  // The next byte is fetched at the last rising edge so that its top bit is
  // ready for the very next falling edge.
  always_ff @(posedge link.sck or posedge link.csN) begin
    if (link.csN) begin
      txByte_q <= 8'h00;
    end else if (link.holdN && byteDone) begin
      if (state_q == ST_OPCODE) begin
        txByte_q <= packStatus(bp_q, wel_q);
      end else if (state_q == ST_ADDR && !isWrite_q) begin
        txByte_q <= memArray[addrIn];
      end else if (state_q == ST_RDATA) begin
        txByte_q <= memArray[addrNext];
      end
    end
  end

  // ========================================================================
  // Write enable latch
  // The clear that ends a write cycle is noted in the frame and applied at
  // the first edge of the next frame, since the link clock may stop once
  // chip select rises; only statusView can observe the latch in between.
  always_ff @(posedge link.sck or negedge rst_b) begin
    if (!rst_b) begin
      wel_q     <= 1'b0;
      welPend_q <= 1'b0;
    end else if (active) begin
      if (state_q == ST_OPCODE && bitCnt_q == 3'h0 && welPend_q) begin
        wel_q     <= 1'b0;
        welPend_q <= 1'b0;
      end
      if (state_q == ST_OPCODE && byteDone) begin
        if (byteIn == `OPC_SET_WEL) begin
          wel_q <= 1'b1;
        end else if (byteIn == `OPC_CLR_WEL) begin
          wel_q <= 1'b0;
        end else if (byteIn == `OPC_STAT_WR
                     || (byteIn[7:4] == 4'h0 && byteIn[2:0] == `OPC_MEM_WR_LO)) begin
          welPend_q <= 1'b1;
        end
      end
    end
  end

  // ========================================================================
  // Block protect bits
  // No reset: they model nonvolatile cells and keep their value across a
  // power-on reset; a status write is the only way to change them.
  always_ff @(posedge link.sck) begin
    if (active && byteDone && state_q == ST_SWRITE && writeOk) begin
      bp_q <= {byteIn[`STAT_BPHI_POS], byteIn[`STAT_BPLO_POS]};
    end
  end

  // ========================================================================
  // Output driver
  // Data changes only on falling edges, most significant bit first.
  always_ff @(negedge link.sck or posedge link.csN) begin
    if (link.csN) begin
      drvEnN_q  <= 1'b1;
      misoBit_q <= 1'b0;
    end else if (link.holdN) begin
      drvEnN_q  <= ~(state_q == ST_RDATA || state_q == ST_SREAD);
      misoBit_q <= txByte_q[~bitCnt_q];
    end
  end

  // Released during hold without losing the bit being shown
  assign link.miso    = misoBit_q;
  assign link.misoEnN = drvEnN_q | ~link.holdN;

  // ========================================================================
  // Status observation
  always_ff @(posedge link.sck or negedge rst_b) begin
    if (!rst_b) begin
      statusView <= `STAT_RESET;
    end else begin
      statusView <= packStatus(bp_q, wel_q);
    end
  end

endmodule : spi_nv_device

// [shared/spi_nv_cfg.svh]
// Constants for the serial nonvolatile memory link: opcodes, status layout,
// protection bases and timing counts. Included by bare name; no logic here.
`ifndef SPI_NV_CFG_SVH
`define SPI_NV_CFG_SVH

// ==========================================================================
// Array geometry
`define NV_ADDR_W        9
`define NV_ADDR_LAST     9'h1ff

// ==========================================================================
// Opcodes (full byte, or the low three bits for memory commands)
`define OPC_SET_WEL      8'h06
`define OPC_CLR_WEL      8'h04
`define OPC_STAT_RD      8'h05
`define OPC_STAT_WR      8'h01
`define OPC_MEM_RD_LO    3'h3
`define OPC_MEM_WR_LO    3'h2
`define OPC_MSB_POS      3

// ==========================================================================
// Status byte fields
`define STAT_BPHI_POS    3
`define STAT_BPLO_POS    2
`define STAT_WEL_POS     1
`define STAT_RESET       8'h00

// ==========================================================================
// Protected range bases
`define PROT_QTR_BASE    9'h180
`define PROT_HALF_BASE   9'h100

// ==========================================================================
// Host timing in master clocks
`define HOST_HALF_SCK    6
`define HOST_HALF_MIN    5

`endif

// [shared/spi_nv_pkg.sv]
// Types shared by both ends of the serial nonvolatile memory link.
// Assumes spi_nv_cfg.svh holds the numeric constants.
package spi_nv_pkg;

  // ========================================================================
  // Device frame states
  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_ADDR,
    ST_WDATA,
    ST_RDATA,
    ST_SREAD,
    ST_SWRITE,
    ST_IGNORE
  } dev_state_t;

  // ========================================================================
  // Host command set and host states
  typedef enum logic [2:0] {
    CMD_SET_WEL,
    CMD_CLR_WEL,
    CMD_STAT_RD,
    CMD_STAT_WR,
    CMD_MEM_RD,
    CMD_MEM_WR
  } cmd_t;

  typedef enum logic [1:0] {
    MS_IDLE,
    MS_RUN,
    MS_TAIL,
    MS_GAP
  } host_state_t;

endpackage : spi_nv_pkg

// [shared/spi_nv_if.sv]
// Serial link between the memory device and its bus master.
// The data-out wire idles high (pull-up) whenever the device does not drive it.
`timescale 1ns/100ps
interface spi_nv_if;
  logic sck;
  logic csN;
  logic mosi;
  logic holdN;
  logic wpN;
  logic miso;
  logic misoEnN;
  logic soWire;

  // Resolved data-out level
  assign soWire = misoEnN ? 1'b1 : miso;

  modport device (
    input  sck,
    input  csN,
    input  mosi,
    input  holdN,
    input  wpN,
    output miso,
    output misoEnN
  );

  modport host (
    output sck,
    output csN,
    output mosi,
    output holdN,
    output wpN,
    input  soWire
  );
endinterface : spi_nv_if

// [verilog/spi_nv_host.sv]
// Master end of the serial nonvolatile memory link. Runs on mclk and makes
// the link clock by dividing it (mode 0, idle low). One command per request.
// Assumes the user holds request fields stable while reqValid is high.
`include "spi_nv_cfg.svh"
`timescale 1ns/100ps
module spi_nv_host
  import spi_nv_pkg::*;
#(
  parameter int HALF = `HOST_HALF_SCK
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // Command request
  input  wire logic       reqValid,
  input  wire cmd_t       reqCmd,
  input  wire logic [8:0] reqAddr,
  input  wire logic [7:0] reqData,
  output      logic       reqReady,
  // Answer
  output      logic       respValid,
  output      logic [7:0] respData,
  // Pin control
  input  wire logic       holdReq,
  input  wire logic       wpAssert,
  // Serial link, master side
  spi_nv_if.host          link
);

  // ========================================================================
  // Elaboration check
  // The returning bit needs three synchroniser stages inside one half period.
  if (HALF < `HOST_HALF_MIN) begin : g_bad_half
    $error("spi_nv_host: HALF too small for the data-out synchroniser");
  end

  // ========================================================================
  // Opcode builder
  function automatic logic [7:0] opcodeOf(input cmd_t c, input logic a8);
    case (c)
      CMD_SET_WEL: opcodeOf = `OPC_SET_WEL;
      CMD_CLR_WEL: opcodeOf = `OPC_CLR_WEL;
      CMD_STAT_RD: opcodeOf = `OPC_STAT_RD;
      CMD_STAT_WR: opcodeOf = `OPC_STAT_WR;
      CMD_MEM_RD:  opcodeOf = {4'h0, a8, `OPC_MEM_RD_LO};
      default:     opcodeOf = {4'h0, a8, `OPC_MEM_WR_LO};
    endcase
  endfunction : opcodeOf

  host_state_t state_q;
  logic [23:0] frame_q;
  logic [4:0]  bitsLeft_q;
  logic [7:0]  phase_q;
  logic [7:0]  rx_q;
  logic        sck_q, csN_q, mosi_q, holdN_q, wpN_q;
  logic        s1_q, s2_q, s3_q, misoV_q;
  logic        phaseEnd;
  logic [7:0]  firstOpc;

  assign phaseEnd = (phase_q == 8'(HALF - 1));
  // Opcode of the pending request; its top bit goes out with chip select
  assign firstOpc = opcodeOf(reqCmd, reqAddr[8]);

  // ========================================================================
  // Data-out synchroniser; a change counts once stages two and three agree
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s1_q    <= 1'b1;
      s2_q    <= 1'b1;
      s3_q    <= 1'b1;
      misoV_q <= 1'b1;
    end else begin
      s1_q <= link.soWire;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        misoV_q <= s3_q;
      end
    end
  end

  // ========================================================================
  // Write-protect pin follows the user level
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wpN_q <= 1'b1;
    end else begin
      wpN_q <= ~wpAssert;
    end
  end

  // ========================================================================
  // Frame engine
  // Hold is moved only in the low phase and the phase counter stops while
  // it is asserted, so the clock never toggles during a pause.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_q    <= MS_IDLE;
      frame_q    <= 24'h000000;
      bitsLeft_q <= 5'h00;
      phase_q    <= 8'h00;
      rx_q       <= 8'h00;
      sck_q      <= 1'b0;
      csN_q      <= 1'b1;
      mosi_q     <= 1'b0;
      holdN_q    <= 1'b1;
      reqReady   <= 1'b0;
      respValid  <= 1'b0;
      respData   <= 8'h00;
    end else begin
      respValid <= 1'b0;
      case (state_q)
        MS_IDLE: begin
          reqReady <= 1'b1;
          if (reqValid && reqReady) begin
            reqReady <= 1'b0;
            csN_q    <= 1'b0;
            phase_q  <= 8'h00;
            state_q  <= MS_RUN;
            case (reqCmd)
              CMD_SET_WEL, CMD_CLR_WEL: begin
                frame_q    <= {opcodeOf(reqCmd, 1'b0), 16'h0000};
                bitsLeft_q <= 5'd8;
              end
              CMD_STAT_RD, CMD_STAT_WR: begin
                frame_q    <= {opcodeOf(reqCmd, 1'b0), reqData, 8'h00};
                bitsLeft_q <= 5'd16;
              end
              default: begin
                frame_q    <= {opcodeOf(reqCmd, reqAddr[8]), reqAddr[7:0], reqData};
                bitsLeft_q <= 5'd24;
              end
            endcase
            mosi_q <= firstOpc[7];
          end
        end
        MS_RUN: begin
          if (!sck_q) begin
            holdN_q <= ~holdReq;
            if (holdN_q && !holdReq) begin
              phase_q <= phase_q + 8'h01;
              if (phaseEnd) begin
                phase_q <= 8'h00;
                sck_q   <= 1'b1;
                rx_q    <= {rx_q[6:0], misoV_q};
              end
            end
          end else begin
            phase_q <= phase_q + 8'h01;
            if (phaseEnd) begin
              phase_q    <= 8'h00;
              sck_q      <= 1'b0;
              frame_q    <= {frame_q[22:0], 1'b0};
              mosi_q     <= frame_q[22];
              bitsLeft_q <= bitsLeft_q - 5'h01;
              if (bitsLeft_q == 5'h01) begin
                state_q   <= MS_TAIL;
                respData  <= rx_q;
                respValid <= 1'b1;
              end
            end
          end
        end
        MS_TAIL: begin
          phase_q <= phase_q + 8'h01;
          if (phaseEnd) begin
            phase_q <= 8'h00;
            csN_q   <= 1'b1;
            state_q <= MS_GAP;
          end
        end
        MS_GAP: begin
          phase_q <= phase_q + 8'h01;
          if (phaseEnd) begin
            phase_q <= 8'h00;
            state_q <= MS_IDLE;
          end
        end
        default: state_q <= MS_IDLE;
      endcase
    end
  end

  assign link.sck   = sck_q;
  assign link.csN   = csN_q;
  assign link.mosi  = mosi_q;
  assign link.holdN = holdN_q;
  assign link.wpN   = wpN_q;

endmodule : spi_nv_host

// [testbench/spi_nv_checker.sv]
// Concurrent checks on the serial link that joins the host and device ends.
// Assumes mclk samples the link and HALF matches the host instance.
`timescale 1ns/100ps
module spi_nv_checker #(
  parameter int HALF = 6
) (
  // Sampling clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Link signals
  input wire logic sck,
  input wire logic csN,
  input wire logic mosi,
  input wire logic holdN,
  input wire logic wpN,
  input wire logic miso,
  input wire logic misoEnN,
  input wire logic soWire
);
  // ==========================================================================
  // Helper counters
  logic [7:0] hiCnt_q;
  logic [5:0] bitCnt_q;
  logic       sck_q;

  // Length of the high phase, so a divider slip shows as a wrong count
  always_ff @(posedge mclk) begin
    if (sck) hiCnt_q <= hiCnt_q + 8'h01;
    else hiCnt_q <= 8'h00;
  end

  always_ff @(posedge mclk) begin
    sck_q <= sck;
  end

  // Rising link clock edges inside one frame
  always_ff @(posedge mclk) begin
    if (csN) bitCnt_q <= 6'h00;
    else if (sck && !sck_q) bitCnt_q <= bitCnt_q + 6'h01;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // ==========================================================================
  // Assertions
  a_idle_release: assert property (csN && $past(csN) |-> misoEnN && soWire)
    else $error("data out driven while deselected");
  a_hold_release: assert property (!holdN |-> misoEnN)
    else $error("data out driven during pause");
  a_hold_sck_low: assert property ($changed(holdN) |-> !sck)
    else $error("pause moved while link clock high");
  a_mosi_sck_low: assert property (!csN && $changed(mosi) |-> !sck)
    else $error("input data moved while link clock high");
  a_miso_steady: assert property (!csN && sck && $past(sck) |-> $stable(miso))
    else $error("output data moved while link clock high");
  a_cs_rise_low: assert property ($rose(csN) |-> !sck)
    else $error("select raised with link clock high");
  a_high_phase: assert property ($fell(sck) |-> hiCnt_q == 8'(HALF))
    else $error("link clock high phase length wrong");
  a_whole_bytes: assert property ($rose(csN) |-> bitCnt_q[2:0] == 3'h0 && bitCnt_q != 6'h00)
    else $error("frame not whole bytes");

  // ==========================================================================
  // Cover points
  c_pause: cover property (!holdN && !csN);
  c_long_frame: cover property ($rose(csN) && bitCnt_q == 6'h18);
  c_drive_low: cover property (!misoEnN && !soWire);
endmodule : spi_nv_checker

// [testbench/tb_top.sv]
// Self-checking bench: host and device joined by the link interface.
// Assumes the host takes one command per request and answers with respValid.
`timescale 1ns/100ps
module tb_top import spi_nv_pkg::*;;
  typedef struct {cmd_t c; logic [8:0] a; logic [7:0] d; logic wp; logic [7:0] e;} row_t;
  localparam int HALF = 5;
  logic       mclk, rst_b, reqValid, reqReady, respValid, holdReq, wpAssert;
  cmd_t       reqCmd;
  logic [8:0] reqAddr;
  logic [7:0] reqData, respData, statusView, got, opc, sh;
  logic [4:0] bc;
  int         fails, cmp_count;
  row_t       rows[$];

  `define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end

  spi_nv_if link();
  spi_nv_device spi_nv_device_inst (.link(link), .rst_b(rst_b), .statusView(statusView));
  spi_nv_host #(.HALF(HALF)) spi_nv_host_inst (.mclk(mclk), .rst_b(rst_b), .reqValid(reqValid),
    .reqCmd(reqCmd), .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady), .respValid(respValid),
    .respData(respData), .holdReq(holdReq), .wpAssert(wpAssert), .link(link));
  spi_nv_checker #(.HALF(HALF)) spi_nv_checker_inst (.mclk(mclk), .rst_b(rst_b), .sck(link.sck),
    .csN(link.csN), .mosi(link.mosi), .holdN(link.holdN), .wpN(link.wpN), .miso(link.miso),
    .misoEnN(link.misoEnN), .soWire(link.soWire));

  // ==========================================================================
  // Wire monitor: opcode bits and last byte seen on data out
  always @(posedge link.sck or posedge link.csN) begin
    if (link.csN) bc <= 5'h00;
    else begin
      if (bc < 5'h08) opc <= {opc[6:0], link.mosi};
      sh <= {sh[6:0], link.soWire};
      bc <= bc + 5'h01;
    end
  end

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  function automatic row_t r(cmd_t c, logic [8:0] a, logic [7:0] d, logic wp, logic [7:0] e);
    r = '{c, a, d, wp, e};
  endfunction : r

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // One command; a pause is requested mid-frame when hl is set
  task automatic run(cmd_t c, logic [8:0] a, logic [7:0] d, logic wp, bit hl, output logic [7:0] q);
    int n;
    n = 0;
    while (reqReady !== 1'b1) begin
      @(posedge mclk); #1; n++;
      if (n > 3000) begin fails++; final_report(); end
    end
    reqCmd = c; reqAddr = a; reqData = d; wpAssert = wp; reqValid = 1'b1;
    @(posedge mclk); #1;
    reqValid = 1'b0;
    n = 0;
    while (respValid !== 1'b1) begin
      @(posedge mclk); #1; n++;
      if (hl && n == 180) holdReq = 1'b1;
      if (hl && n == 230) holdReq = 1'b0;
      if (n > 3000) begin fails++; final_report(); end
    end
    q = respData;
  endtask : run

  // ==========================================================================
  // Main sequence
  initial begin
    rst_b = 1'b1; reqValid = 1'b0; reqCmd = CMD_SET_WEL; reqAddr = 9'h000; reqData = 8'h00;
    holdReq = 1'b0; wpAssert = 1'b0; fails = 0; cmp_count = 0;
    // A real falling edge, so the device's asynchronous reset cannot be missed at time zero
    #1 rst_b = 1'b0;
    repeat (8) @(posedge mclk);
    #1 rst_b = 1'b1;
    `CHK("status after reset", 8'h00, statusView)
    rows = '{r(CMD_SET_WEL,0,0,0,0), r(CMD_STAT_WR,0,8'h00,0,0), r(CMD_STAT_RD,0,0,0,8'h00),
      r(CMD_SET_WEL,0,0,0,0), r(CMD_MEM_WR,9'h000,8'h5a,0,0), r(CMD_MEM_RD,9'h000,0,0,8'h5a),
      r(CMD_SET_WEL,0,0,0,0), r(CMD_MEM_WR,9'h17f,8'ha5,0,0), r(CMD_MEM_RD,9'h17f,0,0,8'ha5),
      r(CMD_SET_WEL,0,0,0,0), r(CMD_MEM_WR,9'h180,8'h3c,0,0), r(CMD_MEM_RD,9'h180,0,0,8'h3c),
      r(CMD_MEM_WR,9'h17f,8'h11,0,0), r(CMD_MEM_RD,9'h17f,0,0,8'ha5),
      r(CMD_SET_WEL,0,0,0,0), r(CMD_CLR_WEL,0,0,0,0), r(CMD_MEM_WR,9'h17f,8'h22,0,0),
      r(CMD_MEM_RD,9'h17f,0,0,8'ha5), r(CMD_SET_WEL,0,0,0,0), r(CMD_STAT_WR,0,8'hf5,0,0),
      r(CMD_STAT_RD,0,0,0,8'h04), r(CMD_SET_WEL,0,0,0,0), r(CMD_MEM_WR,9'h180,8'h77,0,0),
      r(CMD_MEM_RD,9'h180,0,0,8'h3c), r(CMD_SET_WEL,0,0,0,0), r(CMD_MEM_WR,9'h17f,8'h66,0,0),
      r(CMD_MEM_RD,9'h17f,0,0,8'h66), r(CMD_SET_WEL,0,0,1,0), r(CMD_MEM_WR,9'h17f,8'h99,1,0),
      r(CMD_MEM_RD,9'h17f,0,0,8'h66), r(CMD_SET_WEL,0,0,0,0), r(CMD_STAT_WR,0,8'h08,0,0),
      r(CMD_SET_WEL,0,0,0,0), r(CMD_MEM_WR,9'h17f,8'h55,0,0), r(CMD_MEM_RD,9'h17f,0,0,8'h66),
      r(CMD_SET_WEL,0,0,0,0), r(CMD_STAT_WR,0,8'h0c,0,0), r(CMD_SET_WEL,0,0,0,0),
      r(CMD_MEM_WR,9'h000,8'hc3,0,0), r(CMD_MEM_RD,9'h000,0,0,8'h5a), r(CMD_SET_WEL,0,0,1,0),
      r(CMD_STAT_WR,0,8'h00,1,0), r(CMD_STAT_RD,0,0,1,8'h0c)};
    foreach (rows[i]) begin
      run(rows[i].c, rows[i].a, rows[i].d, rows[i].wp, 1'b0, got);
      if (rows[i].c inside {CMD_STAT_RD, CMD_MEM_RD})
        `CHK("answer", rows[i].e, got)
    end
    `CHK("opcode on wire", 8'h05, opc)
    `CHK("status on wire", 8'h0c, sh)
    // Pause in the middle of a read must not lose the byte
    run(CMD_MEM_RD, 9'h180, 8'h00, 1'b0, 1'b1, got);
    `CHK("read across pause", 8'h3c, got)
    // Reset in mid-run clears the latch but keeps the protect bits
    run(CMD_SET_WEL, 9'h000, 8'h00, 1'b0, 1'b0, got);
    `CHK("status view", 8'h0c, statusView)
    repeat (4) @(posedge mclk);
    #1 rst_b = 1'b0;
    repeat (8) @(posedge mclk);
    #1 rst_b = 1'b1;
    `CHK("status view cleared", 8'h00, statusView)
    run(CMD_STAT_RD, 9'h000, 8'h00, 1'b0, 1'b0, got);
    `CHK("status after reset", 8'h0c, got)
    final_report();
  end
endmodule : tb_top
